// [dv/usart_receive_buffer_flags_test.sv]
// Purpose: Self-checking bench joining transmitter end and receiver end
// Assumes: BIT_CYC 8 on both ends; software port with one-cycle strobes
// Notes:   Error frames are produced by the transmitter's injection inputs
`timescale 1ns/1ps
`default_nettype none
`include "usrx_params.svh"

module usart_receive_buffer_flags_test;
    import usrx_pkg::*;
    localparam int BIT_CYC = 8;
    logic       i_clk_sys = 1'b0;
    logic       i_rst     = 1'b1;
    logic [1:0] i_addr    = 2'h0;
    logic [7:0] i_wdata   = 8'h00;
    logic       i_wr      = 1'b0;
    logic       i_rd      = 1'b0;
    logic [7:0] o_rdata;
    logic       o_rx_irq;
    logic       o_pin_claimed;
    logic       tx_send = 1'b0, tx_par_on = 1'b0, tx_par_odd = 1'b0, tx_two_stop = 1'b0;
    logic       tx_bad_stop = 1'b0, tx_bad_par = 1'b0, tx_ready;
    logic [8:0] tx_data = 9'h000;
    logic [2:0] tx_size = 3'h3;
    // Nine-bit frame first, so narrower frames show any stale upper bits
    logic [7:0] mask [5] = '{8'hff, 8'h1f, 8'h3f, 8'h7f, 8'hff};
    logic [2:0] sz;
    int         n_mismatch = 0;
    int         checks = 0;

    always #10 i_clk_sys = ~i_clk_sys;

    usrx_if usrx_if_inst ();
    usrx_tx_end #(.BIT_CYC(BIT_CYC)) usrx_tx_end_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_send(tx_send),
        .i_data(tx_data), .i_char_size_sel(tx_size), .i_parity_on(tx_par_on), .i_parity_odd(tx_par_odd),
        .i_two_stop(tx_two_stop), .i_bad_stop(tx_bad_stop), .i_bad_parity(tx_bad_par), .o_ready(tx_ready),
        .lnk(usrx_if_inst));
    usrx_rx_end #(.BIT_CYC(BIT_CYC)) usrx_rx_end_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rx_irq(o_rx_irq),
        .o_pin_claimed(o_pin_claimed), .lnk(usrx_if_inst));
    usrx_checker usrx_checker_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rx_irq(o_rx_irq), .o_pin_claimed(o_pin_claimed),
        .serial_rx_pin(usrx_if_inst.serial_rx_pin));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("Counts: %0d checks, %0d mismatches", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk_sys);
        i_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string what);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk_sys);
        i_rd   <= 1'b0;
        #1;
        chk({1'b0, o_rdata}, {1'b0, exp}, what);
    endtask : rd

    // Both ends take the same frame format so the receiver can follow
    task automatic cfg(input logic [7:0] c);
        wr(`USRX_OFF_CTRL_C, c);
        tx_size     <= c[2:0];
        tx_par_on   <= c[5];
        tx_par_odd  <= c[4];
        tx_two_stop <= c[3];
    endtask : cfg

    task automatic wait_ready();
        int n;
        #1;
        for (n = 0; n < 400 && tx_ready !== 1'b1; n++)
        begin
            @(posedge i_clk_sys);
            #1;
        end
        if (tx_ready !== 1'b1)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t transmitter stuck busy", $time);
            wrap_up();
        end
    endtask : wait_ready

    task automatic send(input logic [8:0] d, input logic bs, input logic bp);
        wait_ready();
        @(posedge i_clk_sys);
        tx_data     <= d;
        tx_bad_stop <= bs;
        tx_bad_par  <= bp;
        tx_send     <= 1'b1;
        @(posedge i_clk_sys);
        tx_send     <= 1'b0;
    endtask : send

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        rd(`USRX_OFF_CTRL_B, `USRX_CTRL_B_RST, "ctrl_b reset");
        rd(`USRX_OFF_CTRL_C, `USRX_CTRL_C_RST, "ctrl_c reset");
        rd(`USRX_OFF_STATUS, 8'h00, "status reset");
        chk({8'h00, o_pin_claimed}, 9'h000, "pin released");
        $display("Test reset done");

        wr(`USRX_OFF_CTRL_B, 8'h90);
        #1;
        chk({8'h00, o_pin_claimed}, 9'h001, "pin taken");
        for (int s = 0; s < 5; s++)
        begin
            sz = (s == 0) ? `USRX_SIZE_NINE : 3'(s - 1);
            cfg({5'h00, sz});
            send(9'h1ff, 1'b0, 1'b0);
            wait_ready();
            chk({8'h00, o_rx_irq}, 9'h001, "request with data");
            rd(`USRX_OFF_STATUS, 8'h80, "complete set");
            rd(`USRX_OFF_CTRL_B, {6'h24, sz == `USRX_SIZE_NINE, 1'b0}, "ninth bit");
            rd(`USRX_OFF_DATA, mask[s], "masked data");
            rd(`USRX_OFF_STATUS, 8'h00, "complete clear");
            rd(`USRX_OFF_DATA, 8'h00, "empty read");
        end
        $display("Test sizes done");

        // Request enable off: error entries alone must raise nothing
        wr(`USRX_OFF_CTRL_B, 8'h10);
        for (int p = 0; p < 2; p++)
        begin
            cfg({3'b001, p[0], p[0], 3'h3});
            send(9'h0c3, 1'b0, 1'b1);
            send(9'h03c, 1'b1, 1'b0);
            wait_ready();
            chk({8'h00, o_rx_irq}, 9'h000, "no request from errors");
            wr(`USRX_OFF_STATUS, 8'h00);
            rd(`USRX_OFF_STATUS, 8'h84, "parity error");
            wr(`USRX_OFF_CTRL_C, {3'b000, p[0], p[0], 3'h3});
            rd(`USRX_OFF_STATUS, 8'h80, "parity masked");
            wr(`USRX_OFF_CTRL_C, {3'b001, p[0], p[0], 3'h3});
            rd(`USRX_OFF_DATA, 8'hc3, "first entry");
            rd(`USRX_OFF_STATUS, 8'h90, "frame error");
            rd(`USRX_OFF_DATA, 8'h3c, "second entry");
        end
        $display("Test errors done");

        cfg(8'h06);
        for (int k = 1; k < 5; k++)
            send({1'b0, k[7:0]}, 1'b0, 1'b0);
        wait_ready();
        rd(`USRX_OFF_STATUS, 8'h80, "first clean");
        rd(`USRX_OFF_DATA, 8'h01, "first data");
        rd(`USRX_OFF_STATUS, 8'h80, "second clean");
        rd(`USRX_OFF_DATA, 8'h02, "second data");
        rd(`USRX_OFF_STATUS, 8'h88, "overrun shown");
        rd(`USRX_OFF_DATA, 8'h03, "held data");
        rd(`USRX_OFF_STATUS, 8'h00, "lost frame");
        send(9'h055, 1'b0, 1'b0);
        wait_ready();
        rd(`USRX_OFF_STATUS, 8'h80, "overrun cleared");
        rd(`USRX_OFF_DATA, 8'h55, "next data");
        $display("Test overrun done");

        // Disable lands mid-way through the third frame
        wr(`USRX_OFF_CTRL_B, 8'h90);
        send(9'h011, 1'b0, 1'b0);
        send(9'h022, 1'b0, 1'b0);
        send(9'h033, 1'b0, 1'b0);
        repeat (30) @(posedge i_clk_sys);
        wr(`USRX_OFF_CTRL_B, 8'h80);
        #1;
        chk({8'h00, o_pin_claimed}, 9'h000, "pin released");
        rd(`USRX_OFF_STATUS, 8'h00, "flushed");
        wait_ready();
        wr(`USRX_OFF_CTRL_B, 8'h90);
        repeat (2 * BIT_CYC) @(posedge i_clk_sys);
        rd(`USRX_OFF_STATUS, 8'h00, "frame abandoned");
        send(9'h066, 1'b0, 1'b0);
        wait_ready();
        rd(`USRX_OFF_DATA, 8'h66, "after enable");
        $display("Test disable done");
        wrap_up();
    end
endmodule : usart_receive_buffer_flags_test

`default_nettype wire

// [dv/usrx_checker.sv]
// Purpose: Concurrent checks on the receiver end and the serial line
// Assumes: BIT_CYC of 8 on both ends; one bus master driving the strobes
// Notes:   Control bits are shadowed from bus writes, so no internal state is probed
`timescale 1ns/1ps
`default_nettype none
`include "usrx_params.svh"

module usrx_checker
(
    input wire logic       i_clk_sys,     // System clock
    input wire logic       i_rst,         // Synchronous reset
    input wire logic [1:0] i_addr,        // Register offset
    input wire logic [7:0] i_wdata,       // Write data
    input wire logic       i_wr,          // Write strobe
    input wire logic       i_rd,          // Read strobe
    input wire logic [7:0] o_rdata,       // Read data
    input wire logic       o_rx_irq,      // Receive request
    input wire logic       o_pin_claimed, // Receiver owns the pin
    input wire logic       serial_rx_pin  // Serial line
);
    logic irq_en_r;
    logic rx_en_r;
    logic par_on_r;
    wire  wr_ctrl_b = i_wr && (i_addr == `USRX_OFF_CTRL_B);
    wire  wr_ctrl_c = i_wr && (i_addr == `USRX_OFF_CTRL_C);

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            irq_en_r <= 1'b0;
            rx_en_r  <= 1'b0;
            par_on_r <= 1'b0;
        end
        else
        begin
            if (wr_ctrl_b)
            begin
                irq_en_r <= i_wdata[`USRX_CB_IRQ_EN];
                rx_en_r  <= i_wdata[`USRX_CB_RX_EN];
            end
            if (wr_ctrl_c)
                par_on_r <= i_wdata[`USRX_CC_PAR_ON];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    sequence s_stat_rd;
        i_rd && (i_addr == `USRX_OFF_STATUS);
    endsequence

    sequence s_data_rd;
        i_rd && (i_addr == `USRX_OFF_DATA);
    endsequence

    a_irq_mirror: assert property (s_stat_rd ##0 irq_en_r |=> o_rdata[`USRX_STAT_RXC] == $past(o_rx_irq))
        else $error("request level differs from receive complete flag");
    a_irq_needs_en: assert property (o_rx_irq |-> irq_en_r)
        else $error("request without its enable");
    a_pin_follows: assert property (o_pin_claimed == rx_en_r)
        else $error("pin ownership differs from receiver enable");
    a_off_flush: assert property ($fell(o_pin_claimed) |-> ##[0:1] (!o_rx_irq && !o_pin_claimed) [*8])
        else $error("buffer not flushed by receiver disable");
    a_rdata_gap: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside the answer cycle");
    a_par_off: assert property (s_stat_rd ##0 !par_on_r |=> !o_rdata[`USRX_STAT_PE])
        else $error("parity error shown with checking off");
    a_empty_read: assert property (s_data_rd ##0 (irq_en_r && !o_rx_irq) |=> o_rdata == 8'h00)
        else $error("data from an empty buffer");
    a_line_bit: assert property ($fell(serial_rx_pin) |-> (!serial_rx_pin) [*8])
        else $error("low bit on the line shorter than a bit period");
    a_ctrl_back: assert property (i_rd && (i_addr == `USRX_OFF_CTRL_B) |=>
        (o_rdata[7] == $past(irq_en_r)) && (o_rdata[4] == $past(rx_en_r)))
        else $error("control read back differs from written bits");
endmodule : usrx_checker

`default_nettype wire

// [hw/usrx_if.sv]
// Purpose: Serial receive line between the remote transmitter and the receiver
// Assumes: Line idles high; one driver, the transmitter end
// Notes:   No clocking block; both ends share i_clk_sys
`timescale 1ns/1ps
`default_nettype none

interface usrx_if;
    logic serial_rx_pin;

    modport tx_end (output serial_rx_pin);
    modport rx_end (input  serial_rx_pin);
endinterface : usrx_if

`default_nettype wire

// [hw/usrx_params.svh]
// Purpose: Constants of the receive buffer block: offsets, field positions, reset values, timing
// Assumes: Included by bare name from the package file, the bench and the checker
// Notes:   Offsets are byte indices on the 2-bit software port
`ifndef USRX_PARAMS_SVH
`define USRX_PARAMS_SVH

`define USRX_OFF_STATUS    2'h0
`define USRX_OFF_CTRL_B    2'h1
`define USRX_OFF_CTRL_C    2'h2
`define USRX_OFF_DATA      2'h3

`define USRX_STAT_RXC      7
`define USRX_STAT_FE       4
`define USRX_STAT_DOR      3
`define USRX_STAT_PE       2

`define USRX_CB_IRQ_EN     7
`define USRX_CB_RX_EN      4
`define USRX_CB_RX_NINTH   1
`define USRX_CB_TX_NINTH   0

`define USRX_CC_PAR_ON     5
`define USRX_CC_PAR_ODD    4
`define USRX_CC_STOP2      3
`define USRX_CC_SIZE_HI    2
`define USRX_CC_SIZE_LO    0

`define USRX_CTRL_B_RST    8'h00
`define USRX_CTRL_C_RST    8'h06
`define USRX_SIZE_NINE     3'h7

`define USRX_BIT_CYC_DEF   16

`endif

// [hw/usrx_pkg.sv]
// Purpose: Shared types of the receive buffer block
// Assumes: usrx_params.svh holds the numbers
// Notes:   One buffer entry carries data and its own error status
`include "usrx_params.svh"

package usrx_pkg;

    typedef struct packed {
        logic [8:0] data;
        logic       fe;
        logic       dor;
        logic       pe;
    } usrx_entry_t;

    typedef enum logic [2:0] {
        USRX_IDLE,
        USRX_START,
        USRX_DATA,
        USRX_PAR,
        USRX_STOP
    } usrx_rx_state_t;

    typedef enum logic [1:0] {
        USRX_TX_IDLE,
        USRX_TX_SHIFT
    } usrx_tx_state_t;

    // Data bits of a frame for a character size code; unused codes act as eight
    function automatic logic [3:0] usrx_nbits(input logic [2:0] size);
        logic [3:0] n;
        case (size)
            3'h0:    n = 4'h5;
            3'h1:    n = 4'h6;
            3'h2:    n = 4'h7;
            3'h7:    n = 4'h9;
            default: n = 4'h8;
        endcase
        return n;
    endfunction : usrx_nbits

endpackage : usrx_pkg

// [hw/usrx_rx_end.sv]
// Purpose: Receiver end: frame capture, two-entry receive buffer, flags and software registers
// Assumes: Software port with one-cycle strobes; read data one cycle after the read strobe
// Notes:   Bit timing is a fixed count per bit; majority sampling is not modelled
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module usrx_rx_end
    import usrx_pkg::*;
#(
    parameter int BIT_CYC = `USRX_BIT_CYC_DEF
)
(
    input  wire logic       i_clk_sys,      // System clock
    input  wire logic       i_rst,          // Synchronous reset, active high
    input  wire logic [1:0] i_addr,         // Register offset
    input  wire logic [7:0] i_wdata,        // Write data
    input  wire logic       i_wr,           // Write strobe
    input  wire logic       i_rd,           // Read strobe
    output logic      [7:0] o_rdata,        // Read data, cycle after i_rd
    output logic            o_rx_irq,       // Receive complete request, level
    output logic            o_pin_claimed,  // Receiver owns the serial pin
    usrx_if.rx_end          lnk             // Serial line
);

    generate
        if (BIT_CYC < 4 || BIT_CYC > 65536)
        begin : g_chk
            $error("BIT_CYC out of range");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]     ctrl_b_r;
    logic [7:0]     ctrl_c_r;
    logic [7:0]     rdata_r;

    wire logic       rx_en       = ctrl_b_r[`USRX_CB_RX_EN];
    wire logic       irq_en      = ctrl_b_r[`USRX_CB_IRQ_EN];
    wire logic [2:0] size_sel    = ctrl_c_r[`USRX_CC_SIZE_HI:`USRX_CC_SIZE_LO];
    wire logic       par_on      = ctrl_c_r[`USRX_CC_PAR_ON];
    wire logic       par_odd     = ctrl_c_r[`USRX_CC_PAR_ODD];
    wire logic [3:0] nbits       = usrx_nbits(size_sel);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser; the pin is ignored while released
    logic pin_s1_r;
    logic pin_s2_r;

    assign o_pin_claimed = rx_en;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
        end
        else
        begin
            pin_s1_r <= lnk.serial_rx_pin;
            pin_s2_r <= pin_s1_r;
        end
    end

    wire logic line = pin_s2_r | ~rx_en;

    ////////////////////////////////////////////////////////////////////////////////
    // Receive buffer: two entries in flops plus one held frame in a separate hold register
    usrx_entry_t    fifo_r [2];
    logic           wp_r;
    logic           rp_r;
    logic [1:0]     cnt_r;
    usrx_entry_t    hold_r;
    logic           hold_v_r;
    logic           ovr_pend_r;

    usrx_entry_t    head;
    usrx_entry_t    new_ent;
    logic           frame_done;
    logic           start_ok;

    wire logic full      = (cnt_r == 2'h2);
    wire logic rx_cmp    = (cnt_r != 2'h0);
    wire logic pop       = i_rd && (i_addr == `USRX_OFF_DATA) && rx_cmp;
    wire logic push_hold = hold_v_r && !full;
    wire logic push_new  = frame_done && !hold_v_r && !full;
    wire logic to_hold   = frame_done && !hold_v_r && full;
    wire logic push      = push_hold || push_new;
    wire logic ovr_set   = start_ok && full && hold_v_r;
    wire usrx_entry_t push_ent = push_hold ? hold_r : new_ent;

    assign head = fifo_r[rp_r];

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || !rx_en)
        begin
            wp_r       <= 1'b0;
            rp_r       <= 1'b0;
            cnt_r      <= 2'h0;
            hold_v_r   <= 1'b0;
            ovr_pend_r <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                fifo_r[wp_r]     <= push_ent;
                fifo_r[wp_r].dor <= ovr_pend_r;
                wp_r             <= ~wp_r;
            end
            if (pop)
                rp_r <= ~rp_r;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
            if (to_hold)
                hold_r <= new_ent;
            hold_v_r   <= (hold_v_r && !push_hold) || to_hold;
            // A new overrun in the transfer cycle is kept: the set wins
            ovr_pend_r <= ovr_set || (ovr_pend_r && !push);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame capture
    usrx_rx_state_t state_r;
    logic [15:0]    bcnt_r;
    logic [3:0]     idx_r;
    logic [8:0]     data_r;
    logic           par_acc_r;
    logic           pe_r;

    wire logic half_end = (bcnt_r == 16'(BIT_CYC / 2 - 1));
    wire logic bit_end  = (bcnt_r == 16'(BIT_CYC - 1));

    assign start_ok   = (state_r == USRX_START) && half_end && !line;
    assign frame_done = (state_r == USRX_STOP) && bit_end;
    assign new_ent    = '{data: data_r, fe: ~line, dor: 1'b0, pe: pe_r};

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || !rx_en)
        begin
            state_r   <= USRX_IDLE;
            bcnt_r    <= 16'h0000;
            idx_r     <= 4'h0;
            data_r    <= 9'h000;
            par_acc_r <= 1'b0;
            pe_r      <= 1'b0;
        end
        else
        begin
            bcnt_r <= (bit_end || (state_r == USRX_IDLE)) ? 16'h0000 : bcnt_r + 16'h0001;
            case (state_r)
                USRX_IDLE:
                    if (!line)
                        state_r <= USRX_START;
                USRX_START:
                    if (half_end)
                    begin
                        bcnt_r    <= 16'h0000;
                        idx_r     <= 4'h0;
                        data_r    <= 9'h000;
                        par_acc_r <= 1'b0;
                        pe_r      <= 1'b0;
                        state_r   <= line ? USRX_IDLE : USRX_DATA;
                    end
                USRX_DATA:
                    if (bit_end)
                    begin
                        data_r[idx_r] <= line;
                        par_acc_r     <= par_acc_r ^ line;
                        idx_r         <= idx_r + 4'h1;
                        if (idx_r == nbits - 4'h1)
                            state_r <= par_on ? USRX_PAR : USRX_STOP;
                    end
                USRX_PAR:
                    if (bit_end)
                    begin
                        pe_r    <= par_acc_r ^ line ^ par_odd;
                        state_r <= USRX_STOP;
                    end
                USRX_STOP:
                    // The frame ends at the first stop; a second one looks like idle
                    if (bit_end)
                        state_r <= USRX_IDLE;
                default: state_r <= USRX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Software port
    logic [7:0] status_rd;
    logic [7:0] ctrl_b_rd;
    logic [7:0] rd_mux;

    always_comb
    begin
        status_rd                   = 8'h00;
        status_rd[`USRX_STAT_RXC]   = rx_cmp;
        status_rd[`USRX_STAT_FE]    = rx_cmp && head.fe;
        status_rd[`USRX_STAT_DOR]   = rx_cmp && head.dor;
        status_rd[`USRX_STAT_PE]    = rx_cmp && head.pe && par_on;
        ctrl_b_rd                   = ctrl_b_r;
        ctrl_b_rd[`USRX_CB_RX_NINTH] = rx_cmp && head.data[8];
    end

    assign rd_mux = (i_addr == `USRX_OFF_STATUS) ? status_rd :
                    (i_addr == `USRX_OFF_CTRL_B) ? ctrl_b_rd :
                    (i_addr == `USRX_OFF_CTRL_C) ? ctrl_c_r  :
                    (rx_cmp ? head.data[7:0] : 8'h00);

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            ctrl_b_r <= `USRX_CTRL_B_RST;
            ctrl_c_r <= `USRX_CTRL_C_RST;
            rdata_r  <= 8'h00;
        end
        else
        begin
            // The status offset holds no writable bit, so error flags stay put
            if (i_wr && (i_addr == `USRX_OFF_CTRL_B))
                ctrl_b_r <= i_wdata & ~(8'h01 << `USRX_CB_RX_NINTH);
            if (i_wr && (i_addr == `USRX_OFF_CTRL_C))
                ctrl_c_r <= i_wdata;
            rdata_r <= i_rd ? rd_mux : 8'h00;
        end
    end

    assign o_rdata  = rdata_r;
    assign o_rx_irq = irq_en && rx_cmp;

endmodule : usrx_rx_end

`default_nettype wire

// [hw/usrx_tx_end.sv]
// Purpose: Remote transmitter end driving the serial receive line
// Assumes: Same bit period as the receiver, in system clocks
// Notes:   Error injection inputs let the far end produce bad stop or parity bits
`timescale 1ns/1ps
`default_nettype none

module usrx_tx_end
    import usrx_pkg::*;
#(
    parameter int BIT_CYC = `USRX_BIT_CYC_DEF
)
(
    input  wire logic       i_clk_sys,      // System clock
    input  wire logic       i_rst,          // Synchronous reset, active high
    input  wire logic       i_send,         // Pulse: send i_data as one frame
    input  wire logic [8:0] i_data,         // Character, low bits used
    input  wire logic [2:0] i_char_size_sel,// Character size code
    input  wire logic       i_parity_on,    // Append a parity bit
    input  wire logic       i_parity_odd,   // Odd parity when high
    input  wire logic       i_two_stop,     // Second stop bit
    input  wire logic       i_bad_stop,     // Send first stop bit as zero
    input  wire logic       i_bad_parity,   // Invert the parity bit
    output logic            o_ready,        // High when a send is taken
    usrx_if.tx_end          lnk             // Serial line
);

    generate
        // The bit counter is 16 bits wide, so longer bit periods cannot be counted
        if (BIT_CYC < 4 || BIT_CYC > 65536)
        begin : g_chk
            $error("BIT_CYC out of range");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    usrx_tx_state_t state_r;
    logic [12:0]    frame_r;
    logic [3:0]     left_r;
    logic [15:0]    cnt_r;
    logic           line_r;

    wire logic [3:0]  nb     = usrx_nbits(i_char_size_sel);
    wire logic [8:0]  dmask  = 9'h1ff >> (4'h9 - nb);
    wire logic [8:0]  dbits  = i_data & dmask;
    wire logic        par    = (^dbits) ^ i_parity_odd ^ i_bad_parity;
    // Frame LSB first: start, data, optional parity, stops; idle ones fill the rest
    wire logic [12:0] tail   = {11'h7ff, ~i_bad_stop, i_parity_on ? par : ~i_bad_stop};
    // Tail starts one past the last data bit, which sits at position nb
    wire logic [12:0] shaped = ((i_parity_on ? tail : {1'b1, tail[12:1]}) << (nb + 4'h1)) | {3'h0, dbits, 1'b0};
    wire logic [3:0]  total  = 4'h2 + nb + {3'h0, i_parity_on} + {3'h0, i_two_stop};
    wire logic        bit_end = (cnt_r == 16'(BIT_CYC - 1));

    assign o_ready           = (state_r == USRX_TX_IDLE);
    assign lnk.serial_rx_pin = line_r;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            state_r <= USRX_TX_IDLE;
            frame_r <= 13'h1fff;
            left_r  <= 4'h0;
            cnt_r   <= 16'h0000;
            line_r  <= 1'b1;
        end
        else
        begin
            case (state_r)
                USRX_TX_IDLE:
                begin
                    line_r <= 1'b1;
                    if (i_send)
                    begin
                        frame_r <= {1'b1, shaped[12:1]};
                        line_r  <= 1'b0;
                        left_r  <= total - 4'h1;
                        cnt_r   <= 16'h0000;
                        state_r <= USRX_TX_SHIFT;
                    end
                end
                USRX_TX_SHIFT:
                begin
                    cnt_r <= bit_end ? 16'h0000 : cnt_r + 16'h0001;
                    if (bit_end)
                    begin
                        if (left_r == 4'h0)
                        begin
                            line_r  <= 1'b1;
                            state_r <= USRX_TX_IDLE;
                        end
                        else
                        begin
                            line_r  <= frame_r[0];
                            frame_r <= {1'b1, frame_r[12:1]};
                            left_r  <= left_r - 4'h1;
                        end
                    end
                end
                default: state_r <= USRX_TX_IDLE;
            endcase
        end
    end

endmodule : usrx_tx_end

`default_nettype wire
